// file: design/motion_interrupt_status_hub.sv
// interrupt status hub: trigger select, mode status, interrupt sources
`timescale 1ns/1ns
module motion_interrupt_status_hub
  import motion_irq_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          rstn,
  input  wire logic          regWrite,
  input  wire logic          regRead,
  input  wire logic [7:0]    regAddr,
  input  wire logic [7:0]    regWdata,
  output logic [7:0]         regRdata,
  input  wire logic          activeMode,
  input  wire event_levels_t eventLevels,
  input  wire irq_enables_t  irqEnables,
  input  wire logic [6:0]    wakeSources,
  input  wire clear_reads_t  clearReads,
  input  wire logic [15:0]   inactivityLimit,
  input  wire logic          odrTick,
  input  wire logic          gateErrorPulse,
  input  wire logic          fifoEmpty,
  input  wire logic          trigModeSel,
  input  wire logic [5:0]    fifoWatermark,
  input  wire logic          fifoSampleIn,
  output logic               fifoTrigger,
  output logic               fifoAccept,
  output logic               lowRateSel,
  output logic [7:0]         interruptSources
);

  function automatic logic rise(input logic now, input logic prev);
    return now & ~prev;
  endfunction

  logic [3:0]    trigSel_reg;
  logic [3:0]    trigEvtPrev_reg;
  logic [3:0]    trigLatch_reg;
  op_mode_t      mode_reg;
  logic          gateErr_reg;
  logic [4:0]    gateTick_reg;
  logic [7:0]    src_reg;
  logic [6:0]    condPrev_reg;
  logic [15:0]   idleCnt_reg;
  logic [5:0]    postCnt_reg;
  logic          triggered_reg;
  logic          stopped_reg;
  logic [3:0]    trigEvt;
  logic [6:0]    cond;
  logic [7:0]    srcClr;
  logic          modeRead;
  logic          anyIrq;
  logic          wakeEvt;
  logic          toSleep;
  logic          toWake;

  // trigger select register
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      trigSel_reg <= TRIG_SEL_RESET;
    end else if (regWrite && regAddr == TRIG_SEL_ADDR) begin
      trigSel_reg <= regWdata[TRIG_TRANSIENT_BIT:TRIG_FFMT_BIT];
    end
  end

  // function events gated by select bits, order trans/orient/tap/ffmt
  assign trigEvt = {eventLevels.transient, eventLevels.orientation,
                    eventLevels.tap, eventLevels.freefallMotion};

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      trigEvtPrev_reg <= 4'h0;
      trigLatch_reg   <= 4'h0;
    end else begin
      trigEvtPrev_reg <= trigEvt;
      for (int i = 0; i < 4; i++) begin
        if (trigSel_reg[i] && rise(trigEvt[i], trigEvtPrev_reg[i])) begin
          trigLatch_reg[i] <= 1'b1;
        end else if (srcClr[SRC_FFMT_BIT + i]) begin
          trigLatch_reg[i] <= 1'b0;
        end
      end
    end
  end

  // trigger mode: count 32 minus watermark samples after trigger
  always_ff @(posedge ref_clk) begin
    if (!rstn || !trigModeSel) begin
      triggered_reg <= 1'b0;
      stopped_reg   <= 1'b0;
      postCnt_reg   <= 6'h00;
    end else if (!triggered_reg) begin
      if (|trigLatch_reg) begin
        triggered_reg <= 1'b1;
        postCnt_reg   <= FIFO_DEPTH - fifoWatermark;
        stopped_reg   <= (FIFO_DEPTH == fifoWatermark);
      end
    end else if (fifoSampleIn && !stopped_reg) begin
      postCnt_reg <= postCnt_reg - 6'h01;
      if (postCnt_reg <= 6'h01) begin
        stopped_reg <= 1'b1;
      end
    end
  end

  // interrupt source conditions, index matches source bit
  assign cond[6] = irqEnables.fifo &
                   (eventLevels.fifoOvf | eventLevels.fifoWmrk);
  assign cond[5] = irqEnables.transient & eventLevels.transient;
  assign cond[4] = irqEnables.orientation & eventLevels.orientation;
  assign cond[3] = irqEnables.tap & eventLevels.tap;
  assign cond[2] = irqEnables.freefallMotion &
                   eventLevels.freefallMotion;
  assign cond[1] = 1'b0;
  assign cond[0] = irqEnables.drdy &
                   (eventLevels.newData | eventLevels.overrun);

  assign modeRead = regRead && regAddr == OPMODE_ADDR;
  assign srcClr = {modeRead, clearReads.fifoStatus,
                   clearReads.transientSrc, clearReads.orientationStatus,
                   clearReads.tapSrc, clearReads.freefallSrc, 1'b0,
                   clearReads.xyzData};

  // auto-sleep/wake sequencing
  assign anyIrq  = |(cond & ~condPrev_reg);
  assign wakeEvt = |(cond & ~condPrev_reg & wakeSources);
  assign toSleep = mode_reg == MODE_WAKE && irqEnables.aslp &&
                   odrTick && idleCnt_reg >= inactivityLimit;
  assign toWake  = mode_reg == MODE_SLEEP && wakeEvt;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      mode_reg <= MODE_STANDBY;
    end else begin
      unique case (mode_reg)
        MODE_STANDBY: begin
          if (activeMode) begin
            mode_reg <= MODE_WAKE;
          end
        end
        MODE_WAKE: begin
          if (!activeMode) begin
            mode_reg <= MODE_STANDBY;
          end else if (toSleep) begin
            mode_reg <= MODE_SLEEP;
          end
        end
        MODE_SLEEP: begin
          if (!activeMode) begin
            mode_reg <= MODE_STANDBY;
          end else if (toWake) begin
            mode_reg <= MODE_WAKE;
          end
        end
        default: mode_reg <= MODE_STANDBY;
      endcase
    end
  end

  // inactivity counter in odr units, restarts on any interrupt
  always_ff @(posedge ref_clk) begin
    if (!rstn || mode_reg != MODE_WAKE || anyIrq) begin
      idleCnt_reg <= 16'h0000;
    end else if (odrTick && idleCnt_reg != 16'hFFFF) begin
      idleCnt_reg <= idleCnt_reg + 16'h0001;
    end
  end

  // interrupt source flags: set on rise, set beats clear
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      src_reg      <= INT_SRC_RESET;
      condPrev_reg <= 7'h00;
    end else begin
      condPrev_reg <= cond;
      for (int i = 0; i < 7; i++) begin
        if (rise(cond[i], condPrev_reg[i])) begin
          src_reg[i] <= 1'b1;
        end else if (srcClr[i]) begin
          src_reg[i] <= 1'b0;
        end
      end
      if (toSleep || toWake) begin
        src_reg[AUTOSLEEP_FLAG_BIT] <= 1'b1;
      end else if (modeRead) begin
        src_reg[AUTOSLEEP_FLAG_BIT] <= 1'b0;
      end
    end
  end

  // gate error flag and tick counter
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      gateErr_reg  <= 1'b0;
      gateTick_reg <= GATE_TICK_RESET;
    end else if (gateErrorPulse) begin
      gateErr_reg <= 1'b1;
    end else if (fifoEmpty) begin
      gateErr_reg  <= 1'b0;
      gateTick_reg <= GATE_TICK_RESET;
    end else if (gateErr_reg && odrTick) begin
      gateTick_reg <= gateTick_reg + 5'h01;
    end
  end

  // read data and registered outputs
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      regRdata         <= 8'h00;
      fifoTrigger      <= 1'b0;
      fifoAccept       <= 1'b1;
      lowRateSel       <= 1'b0;
      interruptSources <= INT_SRC_RESET;
    end else begin
      unique case (regAddr)
        TRIG_SEL_ADDR: regRdata <= {2'h0, trigSel_reg, 2'h0};
        OPMODE_ADDR:   regRdata <= {gateErr_reg, gateTick_reg,
                                    mode_reg};
        INT_SRC_ADDR:  regRdata <= src_reg;
        default:       regRdata <= 8'h00;
      endcase
      fifoTrigger      <= |trigLatch_reg;
      fifoAccept       <= !stopped_reg;
      lowRateSel       <= (mode_reg == MODE_SLEEP);
      interruptSources <= src_reg;
    end
  end

endmodule

// file: design/motion_irq_pkg.sv
// package: register map, field positions, reset values and carrier types
package motion_irq_pkg;
  // register offsets
  localparam logic [7:0] TRIG_SEL_ADDR   = 8'h0A;
  localparam logic [7:0] OPMODE_ADDR     = 8'h0B;
  localparam logic [7:0] INT_SRC_ADDR    = 8'h0C;
  // trigger select field positions
  localparam int TRIG_TRANSIENT_BIT = 5;
  localparam int TRIG_ORIENT_BIT = 4;
  localparam int TRIG_TAP_BIT    = 3;
  localparam int TRIG_FFMT_BIT   = 2;
  // interrupt source field positions
  localparam int AUTOSLEEP_FLAG_BIT  = 7;
  localparam int FIFO_FLAG_BIT       = 6;
  localparam int TRANSIENT_FLAG_BIT  = 5;
  localparam int SRC_ORIENT_BIT  = 4;
  localparam int SRC_TAP_BIT     = 3;
  localparam int SRC_FFMT_BIT    = 2;
  localparam int NEW_SAMPLE_FLAG_BIT = 0;
  // reset values
  localparam logic [3:0] TRIG_SEL_RESET  = 4'h0;
  localparam logic [4:0] GATE_TICK_RESET = 5'h00;
  localparam logic [7:0] INT_SRC_RESET   = 8'h00;
  // fifo geometry
  localparam logic [5:0] FIFO_DEPTH      = 6'h20;

  // operating mode codes, binary 0/1/2 along standby-wake-sleep
  typedef enum logic [1:0] {
    MODE_STANDBY = 2'h0,
    MODE_WAKE    = 2'h1,
    MODE_SLEEP   = 2'h2
  } op_mode_t;

  // event-active levels from the embedded functions
  typedef struct packed {
    logic fifoOvf;
    logic fifoWmrk;
    logic transient;
    logic orientation;
    logic tap;
    logic freefallMotion;
    logic newData;
    logic overrun;
  } event_levels_t;

  // interrupt enables per source
  typedef struct packed {
    logic aslp;
    logic fifo;
    logic transient;
    logic orientation;
    logic tap;
    logic freefallMotion;
    logic drdy;
  } irq_enables_t;

  // clearing reads of source registers elsewhere in the device
  typedef struct packed {
    logic fifoStatus;
    logic transientSrc;
    logic orientationStatus;
    logic tapSrc;
    logic freefallSrc;
    logic xyzData;
  } clear_reads_t;
endpackage

// file: dv/motion_irq_sva.sv
// checker on the interrupt status hub ports
`timescale 1ns/1ns
module motion_irq_sva
  import motion_irq_pkg::*;
(
  input wire logic          ref_clk,
  input wire logic          rstn,
  input wire logic          regWrite,
  input wire logic          regRead,
  input wire logic [7:0]    regAddr,
  input wire logic [7:0]    regWdata,
  input wire logic [7:0]    regRdata,
  input wire event_levels_t eventLevels,
  input wire irq_enables_t  irqEnables,
  input wire clear_reads_t  clearReads,
  input wire logic          fifoTrigger,
  input wire logic          lowRateSel,
  input wire logic [7:0]    interruptSources
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic [3:0] selReg;
  logic [3:0] lvlPrev;
  logic [3:0] enPrev;
  logic [3:0] trigRise;
  // levels [5:2], enables [4:1]: transient, orientation, tap, freefall
  assign trigRise = selReg & eventLevels[5:2]
                  & (~lvlPrev | (irqEnables[4:1] & ~enPrev));
  always_ff @(posedge ref_clk) begin
    if (!rstn)
      selReg <= TRIG_SEL_RESET;
    else if (regWrite && regAddr == TRIG_SEL_ADDR)
      selReg <= regWdata[5:2];
  end
  always_ff @(posedge ref_clk) begin
    lvlPrev <= eventLevels[5:2];
    enPrev  <= irqEnables[4:1];
  end
  AST_TRIG_RISE: assert property (
    $rose(fifoTrigger) |-> $past(|trigRise, 2))
    else $error("trigger latched without selected rise");
  AST_TRIG_FALL: assert property (
    $fell(fifoTrigger) |-> $past(|clearReads[4:1], 2))
    else $error("trigger dropped without source read");
  AST_TRANS_SET: assert property (
    $rose(eventLevels.transient && irqEnables.transient)
    |-> ##2 interruptSources[TRANSIENT_FLAG_BIT])
    else $error("transient source bit not set");
  AST_DRDY_SET: assert property (
    $rose((eventLevels.newData || eventLevels.overrun) && irqEnables.drdy)
    |-> ##2 interruptSources[NEW_SAMPLE_FLAG_BIT])
    else $error("data ready source bit not set");
  AST_DRDY_HOLD: assert property (
    $fell(interruptSources[NEW_SAMPLE_FLAG_BIT])
    |-> $past(clearReads.xyzData, 2))
    else $error("data ready cleared without sample read");
  AST_ASLP_CLEAR: assert property (
    $fell(interruptSources[AUTOSLEEP_FLAG_BIT])
    |-> $past(regRead && regAddr == OPMODE_ADDR, 2))
    else $error("autosleep flag cleared without mode read");
  AST_SLEEP_FLAG: assert property (
    $rose(lowRateSel) |-> ##[0:2] interruptSources[AUTOSLEEP_FLAG_BIT])
    else $error("sleep entry without autosleep flag");
  AST_MODE_CODE: assert property (
    $past(regAddr) == OPMODE_ADDR |-> regRdata[1:0] != 2'h3)
    else $error("reserved mode code read");
  AST_TICK_ZERO: assert property (
    $past(regAddr) == OPMODE_ADDR && !regRdata[7] |-> regRdata[6:2] == 5'h00)
    else $error("tick count nonzero without gate error");
endmodule

bind motion_interrupt_status_hub motion_irq_sva chk (.*);

// file: dv/host_bus_model.sv
// host model driving the register bus
`timescale 1ns/1ns
module host_bus_model (
  input  wire logic       ref_clk,
  output logic            regWrite,
  output logic            regRead,
  output logic [7:0]      regAddr,
  output logic [7:0]      regWdata,
  input  wire logic [7:0] regRdata
);
  initial begin
    regWrite = 1'b0;
    regRead  = 1'b0;
    regAddr  = 8'h00;
    regWdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
    regWdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1;
    d = regRdata;
  endtask
endmodule

// file: dv/testbench.sv
// self-checking bench for the interrupt status hub
`timescale 1ns/1ns
module testbench;
  import motion_irq_pkg::*;
  logic          ref_clk = 1'b0;
  logic          rstn = 1'b0;
  logic          regWrite, regRead, fifoTrigger, fifoAccept, lowRateSel, tr;
  logic [7:0]    regAddr, regWdata, regRdata, interruptSources, rd;
  logic          activeMode = 1'b0;
  logic          odrTick = 1'b0;
  logic          gateErrorPulse = 1'b0;
  logic          fifoEmpty = 1'b0;
  logic          trigModeSel = 1'b0;
  logic          fifoSampleIn = 1'b0;
  event_levels_t eventLevels = '0;
  irq_enables_t  irqEnables = '1;
  clear_reads_t  clearReads = '0;
  logic [6:0]    wakeSources = 7'h20;
  logic [15:0]   inactivityLimit = 16'h0003;
  logic [5:0]    fifoWatermark = 6'h1C;
  logic [31:0]   seed = 32'h9BD225E2;
  logic [7:0]    addrs [4] = '{TRIG_SEL_ADDR, OPMODE_ADDR, INT_SRC_ADDR, 8'h0D};
  int            srcs [6] = '{6, 5, 4, 3, 2, 0};
  int            mismatches = 0;
  int            num_checks = 0;
  int            lv, cb;
  always #2 ref_clk = ~ref_clk;
  host_bus_model host (.*);
  motion_interrupt_status_hub uut (.*);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge ref_clk) odrTick <= 1'b1;
      @(posedge ref_clk) odrTick <= 1'b0;
    end
    #1;
  endtask
  task automatic clr(input int b);
    @(posedge ref_clk) clearReads[b] <= 1'b1;
    @(posedge ref_clk) clearReads <= '0;
  endtask
  task automatic print_verdict;
    if (mismatches == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    #400000;
    mismatches++;
    print_verdict();
  end
  initial begin
    cyc(3);
    rstn <= 1'b1;
    foreach (addrs[i]) begin
      host.rd(addrs[i], rd);
      cmp("reset value", 8'h00, rd);
    end
    host.wr(TRIG_SEL_ADDR, 8'hFF);
    host.rd(TRIG_SEL_ADDR, rd);
    cmp("trigger select", 8'h3C, rd);
    foreach (srcs[i]) begin
      seed = lfsr(seed);
      host.wr(TRIG_SEL_ADDR, seed[7:0]);
      lv = (srcs[i] == 6) ? 7 : (srcs[i] == 0) ? 1 : srcs[i];
      cb = (srcs[i] == 0) ? 0 : srcs[i] - 1;
      tr = (srcs[i] inside {[2:5]}) ? seed[srcs[i]] : 1'b0;
      @(posedge ref_clk) eventLevels[lv] <= 1'b1;
      cyc(3);
      cmp("source set", 8'h01, interruptSources[srcs[i]]);
      cmp("trigger", tr, fifoTrigger);
      clr((cb + 1) % 6);
      cyc(2);
      cmp("source kept", 8'h01, interruptSources[srcs[i]]);
      clr(cb);
      cyc(3);
      cmp("source cleared", 8'h00, interruptSources[srcs[i]]);
      cmp("trigger cleared", 8'h00, fifoTrigger);
      @(posedge ref_clk) eventLevels <= '0;
    end
    @(posedge ref_clk) irqEnables <= '0;
    @(posedge ref_clk) eventLevels[5] <= 1'b1;
    cyc(3);
    cmp("masked source", 8'h00, interruptSources[5]);
    @(posedge ref_clk) eventLevels <= '0;
    irqEnables <= '1;
    @(posedge ref_clk) gateErrorPulse <= 1'b1;
    @(posedge ref_clk) gateErrorPulse <= 1'b0;
    tick(3);
    host.rd(OPMODE_ADDR, rd);
    cmp("gate error", 8'h8C, rd);
    @(posedge ref_clk) fifoEmpty <= 1'b1;
    @(posedge ref_clk) fifoEmpty <= 1'b0;
    host.rd(OPMODE_ADDR, rd);
    cmp("gate cleared", 8'h00, rd);
    @(posedge ref_clk) activeMode <= 1'b1;
    cyc(2);
    host.rd(OPMODE_ADDR, rd);
    cmp("wake mode", 8'h01, rd);
    tick(5);
    cyc(2);
    cmp("low rate", 8'h01, lowRateSel);
    cmp("sleep flag", 8'h01, interruptSources[7]);
    host.rd(OPMODE_ADDR, rd);
    cmp("sleep mode", 8'h02, rd);
    cyc(2);
    cmp("flag read clear", 8'h00, interruptSources[7]);
    @(posedge ref_clk) eventLevels[5] <= 1'b1;
    cyc(3);
    cmp("high rate", 8'h00, lowRateSel);
    cmp("wake flag", 8'h01, interruptSources[7]);
    @(posedge ref_clk) eventLevels <= '0;
    trigModeSel <= 1'b1;
    clr(4);
    host.wr(TRIG_SEL_ADDR, 8'h20);
    @(posedge ref_clk) eventLevels[5] <= 1'b1;
    cyc(3);
    cmp("mode trigger", 8'h01, fifoTrigger);
    for (int k = 0; k < 4; k++) begin
      cmp("accepting", 8'h01, fifoAccept);
      @(posedge ref_clk) fifoSampleIn <= 1'b1;
      @(posedge ref_clk) fifoSampleIn <= 1'b0;
      #1;
    end
    cyc(2);
    cmp("accept stopped", 8'h00, fifoAccept);
    repeat (400) begin
      @(posedge ref_clk);
      seed = lfsr(seed);
      eventLevels <= seed[7:0];
      irqEnables <= seed[14:8];
      clearReads <= seed[20:15] & seed[26:21];
      odrTick <= seed[27];
    end
    cyc(2);
    print_verdict();
  end
endmodule
